/* File: src/reset_init_register_set.sv */
// Reset-initialisation register set with Avalon-MM slave and wake-up effects
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
//
// Notes on behaviour
// RQ1: Interrupt wake with global enable loads vector.
// RQ2: Interrupt wake pushes PC, advances stack pointer.
// RQ3: Every wake-up sets a cause flag bit.
// RQ4: Port A bits 6,7 only if oscillator frees.
// RQ5: High analog select resets 1_1111, else zero.
// RQ6: Unimplemented bits always read zero.
// RQ7: Priority register 2 resets ones, kept on wake.
// RQ8: Priority register 1 resets 7F, kept on wake.
// RQ9: Flag register 2 clears; wake keeps except cause.
// RQ10: Flag 1 and enable 1 reset zero.
// RQ11: Direction registers reset all inputs, kept.
// RQ12: Latches power up unknown, kept otherwise.
// RQ13: Port B pins reset clear low five bits.
// RQ14: Port A pins reset clear bit5, low four.
// RQ15: Pull-up and low analog select reset ones.
// RQ16: Change-notify resets 0000, slew resets 1_1111.
// RQ17: Comparators and tuning reset zero, kept.
// RQ18: Serial address mask resets ones, kept.
// RQ19: Reset beats wake-up in same cycle.
module reset_init_register_set
    import reset_init_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Reset classes from the reset controller
    input wire logic i_other_reset,
    input wire wake_req_t i_wake,
    input wire logic [PC_W-1:0] i_core_pc,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Core side
    output logic [PC_W-1:0] o_pc_load,
    output logic o_pc_load_valid,
    output logic o_irq
);
    // Byte-wide register file; unused bits of narrow ones are masked on every path, port A top bits on reads only
    logic [7:0] regs_reg [REG_N];
    logic [7:0] regs_next [REG_N];
    logic [PC_W-1:0] pc_reg, pc_next;
    logic [SP_W-1:0] sp_reg, sp_next;
    logic [PC_W-1:0] stack_reg [STK_DEPTH+1];
    logic [PC_W-1:0] stack_next [STK_DEPTH+1];
    logic [EV_W-1:0] ev_stat_reg, ev_stat_next, ev_mask_reg, ev_mask_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic wait_reg;
    logic [PC_W-1:0] pcl_reg, pcl_next;
    logic pcv_reg, pcv_next;
    logic irq_reg, irq_next;
    logic pw_done_reg, pw_done_next;
    reset_class_t cls;

    function automatic int idx(input logic [ADDR_W-1:0] a);
        return int'(a[ADDR_W-1:2]);
    endfunction

    // Per-register implemented bits; oscillator mode gates port A top bits
    function automatic logic [7:0] impl_mask(input int i, input logic osc_free);
        logic [7:0] m;
        m = 8'hFF;
        case (i)
            idx(OFF_IPR_1), idx(OFF_PIR_1), idx(OFF_PIE_1): m = MASK_7BIT; // RQ6
            idx(OFF_DIR_E), idx(OFF_LAT_E): m = 8'h07;
            idx(OFF_ANALOG_SELECT_LOW_H), idx(OFF_SLEW): m = 8'h1F;
            idx(OFF_CHG_B), idx(OFF_CMP_AUX): m = 8'h0F;
            idx(OFF_CFG): m = 8'h03;
            idx(OFF_EVT_STAT), idx(OFF_EVT_MASK): m = 8'h07;
            idx(OFF_DIR_A), idx(OFF_LAT_A), idx(OFF_PINS_A): m = osc_free ? 8'hFF : ~MASK_PORT_A_PINS_OSC; // RQ4
            default: m = 8'hFF;
        endcase
        return m;
    endfunction

    // Value taken on power-on and other resets
    function automatic logic [7:0] init_val(input int i, input logic pbad, input logic [7:0] cur);
        logic [7:0] v;
        v = RST_ZERO;
        case (i)
            idx(OFF_IPR_2), idx(OFF_SER_MASK), idx(OFF_PULL_B), idx(OFF_ANALOG_SELECT_LOW_L): v = RST_ONES; // RQ7 RQ18 RQ15
            idx(OFF_IPR_1): v = RST_IPR_1; // RQ8
            idx(OFF_PIR_1), idx(OFF_PIE_1): v = RST_PIR_1; // RQ10
            idx(OFF_DIR_A), idx(OFF_DIR_B), idx(OFF_DIR_C), idx(OFF_DIR_D): v = RST_ONES; // RQ11
            idx(OFF_DIR_E): v = {5'h00, RST_DIR_E}; // RQ11
            idx(OFF_ANALOG_SELECT_LOW_H): v = pbad ? {3'h0, RST_ANALOG_SELECT_LOW_H} : RST_ZERO; // RQ5
            idx(OFF_SLEW): v = {3'h0, RST_SLEW}; // RQ16
            idx(OFF_CHG_B): v = {4'h0, RST_CHG_B}; // RQ16
            idx(OFF_CMP_AUX): v = {4'h0, RST_CMP_AUX}; // RQ17
            idx(OFF_LAT_A), idx(OFF_LAT_B), idx(OFF_LAT_C), idx(OFF_LAT_D), idx(OFF_LAT_E),
            idx(OFF_CFG), idx(OFF_EVT_MASK): v = cur; // RQ12
            idx(OFF_PINS_B): v = cur & RST_PINS_B_LOW_MASK; // RQ13
            idx(OFF_PINS_A): v = cur & RST_PINS_A_MASK; // RQ14
            default: v = RST_ZERO; // RQ9 RQ17
        endcase
        return v;
    endfunction

    logic osc_free, pbad, is_irq_wake, gie_any;
    logic [31:0] wmask;
    int widx;
    assign osc_free = regs_reg[idx(OFF_CFG)][CFG_OSC_FREE_BIT];
    assign pbad = regs_reg[idx(OFF_CFG)][CFG_PBAD_BIT];
    assign gie_any = regs_reg[idx(OFF_INT_CTRL)][IC_GLOBAL_IRQ_ENABLE_HIGH_BIT] | regs_reg[idx(OFF_INT_CTRL)][IC_GLOBAL_IRQ_ENABLE_LOW_BIT];
    assign is_irq_wake = i_wake.valid && i_wake.by_irq && gie_any;
    assign widx = idx(i_avs_address);

    // Reset outranks wake-up
    always_comb begin
        if (i_other_reset) begin
            cls = CLS_RESET; // RQ19
        end else if (i_wake.valid) begin
            cls = CLS_WAKE;
        end else begin
            cls = CLS_NONE;
        end
    end

    always_comb begin
        for (int i = 0; i < REG_N; i++) begin
            regs_next[i] = regs_reg[i];
        end
        for (int i = 0; i <= STK_DEPTH; i++) begin
            stack_next[i] = stack_reg[i];
        end
        pc_next = pc_reg;
        sp_next = sp_reg;
        ev_stat_next = ev_stat_reg;
        ev_mask_next = ev_mask_reg;
        rdata_next = 32'h0000_0000;
        ack_next = 1'b0;
        pcl_next = pcl_reg;
        pcv_next = 1'b0;
        pw_done_next = pw_done_reg;
        wmask = 32'h0000_0000;
        // Bus read or write, one wait state then acknowledge
        if ((i_avs_read || i_avs_write) && !ack_reg) begin
            ack_next = 1'b1;
            if (i_avs_read && widx < REG_N) begin
                rdata_next = {24'h00_0000, regs_reg[widx] & impl_mask(widx, osc_free)}; // RQ4 RQ6
            end
            if (i_avs_read && i_avs_address == OFF_PC) begin
                rdata_next = {11'h000, pc_reg};
            end
            if (i_avs_read && i_avs_address == OFF_STK_PTR) begin
                rdata_next = {27'h000_0000, sp_reg};
            end
            if (i_avs_read && i_avs_address == OFF_TOS) begin
                rdata_next = {11'h000, stack_reg[sp_reg]};
            end
            if (i_avs_read && i_avs_address == OFF_EVT_STAT) begin
                rdata_next = {29'h0000_0000, ev_stat_reg};
            end
            if (i_avs_read && i_avs_address == OFF_EVT_MASK) begin
                rdata_next = {29'h0000_0000, ev_mask_reg};
            end
            if (i_avs_write && widx < REG_N) begin
                regs_next[widx] = i_avs_writedata[7:0] & impl_mask(widx, 1'b1);
            end
            if (i_avs_write && i_avs_address == OFF_PC) begin
                pc_next = i_avs_writedata[PC_W-1:0];
            end
            if (i_avs_write && i_avs_address == OFF_STK_PTR) begin
                sp_next = i_avs_writedata[SP_W-1:0];
            end
            if (i_avs_write && i_avs_address == OFF_EVT_MASK) begin
                ev_mask_next = i_avs_writedata[EV_W-1:0];
            end
            if (i_avs_write && i_avs_address == OFF_EVT_STAT) begin
                wmask = i_avs_writedata;
                ev_stat_next = ev_stat_reg & ~wmask[EV_W-1:0];
            end
        end
        unique case (cls)
            CLS_RESET: begin
                for (int i = 0; i < REG_N; i++) begin
                    regs_next[i] = init_val(i, pbad, regs_reg[i]) & impl_mask(i, 1'b1);
                end
                pc_next = '0;
                sp_next = '0;
                ev_stat_next[EV_RESET] = 1'b1;
            end
            CLS_WAKE: begin
                ev_stat_next[EV_WAKE] = 1'b1;
                // Cause flag of the wake source
                unique case (i_wake.src_reg)
                    2'd0: regs_next[idx(OFF_PIR_1)][i_wake.src_bit] = i_wake.src_bit != 3'd7; // RQ3 RQ6
                    2'd1: regs_next[idx(OFF_PIR_2)][i_wake.src_bit] = 1'b1; // RQ3 RQ9
                    default: regs_next[idx(OFF_INT_CTRL)][IC_WDT_WAKE_BIT] = 1'b1; // RQ3
                endcase
                if (i_wake.src_reg == 2'd0 && i_wake.src_bit == 3'd7) begin
                    regs_next[idx(OFF_INT_CTRL)][IC_WDT_WAKE_BIT] = 1'b1; // RQ3
                end
                if (is_irq_wake) begin
                    pc_next = i_wake.high_prio ? VEC_HIGH : VEC_LOW; // RQ1
                    pcl_next = pc_next;
                    pcv_next = 1'b1;
                    ev_stat_next[EV_VECTOR] = 1'b1;
                    if (sp_reg < SP_W'(STK_DEPTH)) begin
                        sp_next = sp_reg + 1'b1; // RQ2
                        stack_next[sp_reg + 1'b1] = i_core_pc; // RQ2
                    end
                end
            end
            default: begin
                pc_next = pc_next;
            end
        endcase
        // Power-on done flag: set on the first cycle after reset, read by no other logic
        if (!pw_done_reg) begin
            pw_done_next = 1'b1;
        end
        irq_next = |(ev_stat_next & ev_mask_reg);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            // Power-on: registers with defined values set, latches left unknown
            for (int i = 0; i < REG_N; i++) begin
                regs_reg[i] <= init_val(i, 1'b1, 8'hxx) & impl_mask(i, 1'b1); // RQ12
            end
            // Configuration must be known, or every port A read goes unknown
            regs_reg[idx(OFF_CFG)] <= RST_CFG;
            wait_reg <= 1'b1;
            pc_reg <= '0;
            sp_reg <= '0;
            ev_stat_reg <= '0;
            ev_mask_reg <= '0;
            rdata_reg <= '0;
            ack_reg <= 1'b0;
            pcl_reg <= '0;
            pcv_reg <= 1'b0;
            irq_reg <= 1'b0;
            pw_done_reg <= 1'b0;
        end else begin
            for (int i = 0; i < REG_N; i++) begin
                regs_reg[i] <= regs_next[i];
            end
            for (int i = 0; i <= STK_DEPTH; i++) begin
                stack_reg[i] <= stack_next[i];
            end
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            ev_stat_reg <= ev_stat_next;
            wait_reg <= !ack_next;
            ev_mask_reg <= ev_mask_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            pcl_reg <= pcl_next;
            pcv_reg <= pcv_next;
            irq_reg <= irq_next;
            pw_done_reg <= pw_done_next;
        end
    end

    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_pc_load = pcl_reg;
    assign o_pc_load_valid = pcv_reg;
    assign o_irq = irq_reg;

    wake_vector_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (is_irq_wake && !i_other_reset) |=> o_pc_load_valid &&
        (o_pc_load == VEC_HIGH || o_pc_load == VEC_LOW)) else $error("vector not loaded"); // RQ1
    stack_push_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (is_irq_wake && !i_other_reset && sp_reg < 5'd31) |=> sp_reg == $past(sp_reg) + 5'd1)
        else $error("stack pointer not advanced"); // RQ2
    wake_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_wake.valid && !i_other_reset) |=> (regs_reg[idx(OFF_PIR_1)] | regs_reg[idx(OFF_PIR_2)]
        | regs_reg[idx(OFF_INT_CTRL)]) != 8'h00) else $error("no wake cause"); // RQ3
    prio1_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_other_reset |=> regs_reg[idx(OFF_IPR_1)] == 8'h7F) else $error("priority 1 reset"); // RQ8
    prio2_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_wake.valid && !i_other_reset && !i_avs_write) |=> $stable(regs_reg[idx(OFF_IPR_2)]))
        else $error("priority 2 changed on wake"); // RQ7
    dir_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_other_reset |=> regs_reg[idx(OFF_DIR_D)] == 8'hFF && regs_reg[idx(OFF_DIR_E)] == 8'h07)
        else $error("direction reset"); // RQ11
    analog_select_low_high_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_other_reset |=> regs_reg[idx(OFF_ANALOG_SELECT_LOW_H)] == ($past(pbad) ? 8'h1F : 8'h00))
        else $error("analog select high reset"); // RQ5
    latch_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_other_reset && !i_avs_write) |=> $stable(regs_reg[idx(OFF_LAT_D)])) else $error("latch lost"); // RQ12
    pins_b_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_other_reset |=> regs_reg[idx(OFF_PINS_B)][4:0] == 5'h00) else $error("port b pins reset"); // RQ13
endmodule

/* File: src/reset_init_pkg.sv */
// Package: register map, reset values and reset classes of the reset-init register set
package reset_init_pkg;
    // Register word offsets (byte addresses on the Avalon bus)
    localparam logic [7:0] OFF_IPR_2 = 8'h00;
    localparam logic [7:0] OFF_PIR_2 = 8'h04;
    localparam logic [7:0] OFF_PIE_2 = 8'h08;
    localparam logic [7:0] OFF_IPR_1 = 8'h0C;
    localparam logic [7:0] OFF_PIR_1 = 8'h10;
    localparam logic [7:0] OFF_PIE_1 = 8'h14;
    localparam logic [7:0] OFF_OSC_TUNE = 8'h18;
    localparam logic [7:0] OFF_DIR_E = 8'h1C;
    localparam logic [7:0] OFF_DIR_D = 8'h20;
    localparam logic [7:0] OFF_DIR_C = 8'h24;
    localparam logic [7:0] OFF_DIR_B = 8'h28;
    localparam logic [7:0] OFF_DIR_A = 8'h2C;
    localparam logic [7:0] OFF_LAT_E = 8'h30;
    localparam logic [7:0] OFF_LAT_D = 8'h34;
    localparam logic [7:0] OFF_LAT_C = 8'h38;
    localparam logic [7:0] OFF_LAT_B = 8'h3C;
    localparam logic [7:0] OFF_LAT_A = 8'h40;
    localparam logic [7:0] OFF_PINS_B = 8'h44;
    localparam logic [7:0] OFF_PINS_A = 8'h48;
    localparam logic [7:0] OFF_ANALOG_SELECT_LOW_H = 8'h4C;
    localparam logic [7:0] OFF_ANALOG_SELECT_LOW_L = 8'h50;
    localparam logic [7:0] OFF_CHG_B = 8'h54;
    localparam logic [7:0] OFF_PULL_B = 8'h58;
    localparam logic [7:0] OFF_CMP_1 = 8'h5C;
    localparam logic [7:0] OFF_CMP_2 = 8'h60;
    localparam logic [7:0] OFF_CMP_AUX = 8'h64;
    localparam logic [7:0] OFF_SLEW = 8'h68;
    localparam logic [7:0] OFF_SER_MASK = 8'h6C;
    localparam logic [7:0] OFF_INT_CTRL = 8'h70;
    localparam logic [7:0] OFF_PC = 8'h74;
    localparam logic [7:0] OFF_STK_PTR = 8'h78;
    localparam logic [7:0] OFF_TOS = 8'h7C;
    localparam logic [7:0] OFF_CFG = 8'h80;
    localparam logic [7:0] OFF_EVT_STAT = 8'h84;
    localparam logic [7:0] OFF_EVT_MASK = 8'h88;
    localparam int ADDR_W = 8;
    localparam int REG_N = 35;

    // Reset values
    localparam logic [7:0] RST_ONES = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_IPR_1 = 8'h7F;
    localparam logic [7:0] RST_PIR_1 = 8'h00;
    localparam logic [2:0] RST_DIR_E = 3'h7;
    localparam logic [4:0] RST_ANALOG_SELECT_LOW_H = 5'h1F;
    localparam logic [4:0] RST_SLEW = 5'h1F;
    localparam logic [3:0] RST_CHG_B = 4'h0;
    localparam logic [3:0] RST_CMP_AUX = 4'h0;
    localparam logic [7:0] RST_PINS_B_LOW_MASK = 8'hE0;
    localparam logic [7:0] RST_PINS_A_MASK = 8'hD0;
    // Power-on configuration: port-B-analog set, port A top bits held by the oscillator
    localparam logic [7:0] RST_CFG = 8'h02;

    // Implemented-bit masks
    localparam logic [7:0] MASK_7BIT = 8'h7F;
    localparam logic [7:0] MASK_PORT_A_PINS_OSC = 8'hC0;

    // Program counter and stack
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int STK_DEPTH = 31;
    localparam logic [20:0] VEC_HIGH = 21'h00_0008;
    localparam logic [20:0] VEC_LOW = 21'h00_0018;

    // Config bits at OFF_CFG
    localparam int CFG_OSC_FREE_BIT = 0;
    localparam int CFG_PBAD_BIT = 1;
    // Interrupt-control bits at OFF_INT_CTRL
    localparam int IC_GLOBAL_IRQ_ENABLE_HIGH_BIT = 7;
    localparam int IC_GLOBAL_IRQ_ENABLE_LOW_BIT = 6;
    localparam int IC_WDT_WAKE_BIT = 0;
    // Event status bits
    localparam int EV_RESET = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_VECTOR = 2;
    localparam int EV_W = 3;

    typedef enum logic [2:0] {
        CLS_NONE = 3'b001,
        CLS_RESET = 3'b010,
        CLS_WAKE = 3'b100
    } reset_class_t;

    // Wake-up request from the core
    typedef struct packed {
        logic valid;
        logic by_irq;
        logic high_prio;
        logic [1:0] src_reg;
        logic [2:0] src_bit;
    } wake_req_t;
endpackage

/* File: tb/reset_init_register_set_tb.sv */
// Self-checking bench for the reset-init register set
`timescale 1ns/1ps
module reset_init_register_set_tb;
    import reset_init_pkg::*;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
    } note_t;
    localparam int NT = 19;
    localparam logic [7:0] TA [NT] = '{OFF_IPR_2, OFF_PIR_2, OFF_PIE_2, OFF_IPR_1, OFF_PIR_1, OFF_PIE_1,
        OFF_OSC_TUNE, OFF_DIR_E, OFF_DIR_D, OFF_DIR_C, OFF_DIR_B, OFF_ANALOG_SELECT_LOW_L, OFF_CHG_B, OFF_PULL_B,
        OFF_CMP_1, OFF_CMP_2, OFF_CMP_AUX, OFF_SLEW, OFF_SER_MASK};
    localparam logic [7:0] TV [NT] = '{8'hFF, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h07, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h1F, 8'hFF};
    // Implemented bits of each register
    localparam logic [7:0] TM [NT] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'h07, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h1F, 8'hFF};
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;

    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_other_reset = 1'b0;
    wake_req_t i_wake = '0;
    logic [PC_W-1:0] i_core_pc = '0;
    logic [ADDR_W-1:0] i_avs_address = '0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = '0;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [PC_W-1:0] o_pc_load;
    logic o_pc_load_valid;
    logic o_irq;
    int bad_count = 0;
    int n_compared = 0;
    int seed = 82;
    note_t exp_rd[$];
    logic [PC_W-1:0] exp_pc[$];
    logic [31:0] v [NT];
    logic [31:0] lat;
    logic [PC_W-1:0] pc;

    reset_init_register_set dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_other_reset(i_other_reset), .i_wake(i_wake),
        .i_core_pc(i_core_pc), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_pc_load(o_pc_load), .o_pc_load_valid(o_pc_load_valid),
        .o_irq(o_irq)
    );

    always #50 i_ref_clk = ~i_ref_clk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Bounded wait so a slave that never answers cannot hang the run
    task wait_ack;
        int k;
        for (k = 0; k < 50; k++) begin
            @(posedge i_ref_clk);
            if (o_avs_waitrequest === 1'b0) break;
        end
        if (k == 50) begin
            bad_count++;
            $display("wrong value at %0t: no bus answer", $time);
        end
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        note_t n;
        n.data = e;
        n.mask = m;
        exp_rd.push_back(n);
        i_avs_address <= a;
        i_avs_read <= 1'b1;
        wait_ack();
        i_avs_read <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= 1'b1;
        wait_ack();
        i_avs_write <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task wake(input logic irq, input logic hp, input logic [1:0] sr, input logic [2:0] sb, input logic orst);
        i_wake <= {1'b1, irq, hp, sr, sb};
        i_other_reset <= orst;
        @(posedge i_ref_clk);
        i_wake <= '0;
        i_other_reset <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
    endtask

    task other_rst;
        i_other_reset <= 1'b1;
        @(posedge i_ref_clk);
        i_other_reset <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    // Watches the outputs and settles each note in order
    always @(posedge i_ref_clk) begin
        note_t n;
        if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
            if (exp_rd.size() == 0) begin
                chk(o_avs_readdata, 32'hDEAD_BEEF);
            end else begin
                n = exp_rd.pop_front();
                chk(o_avs_readdata & n.mask, n.data & n.mask);
            end
        end
        if (o_pc_load_valid === 1'b1) begin
            if (exp_pc.size() == 0) begin
                chk(32'(o_pc_load), 32'hDEAD_BEEF);
            end else begin
                chk(32'(o_pc_load), 32'(exp_pc.pop_front()));
            end
        end
    end

    initial begin
        #(100 * 20000);
        bad_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        for (int i = 0; i < NT; i++) rd(TA[i], 32'(TV[i]), ALL);
        rd(OFF_PINS_B, 32'h0000_0000, 32'hFFFF_FF1F);
        rd(OFF_PINS_A, 32'h0000_0000, 32'hFFFF_FF2F);
        rd(8'h8C, 32'h0000_0000, ALL);
        wr(8'h8C, ALL);
        rd(8'h8C, 32'h0000_0000, ALL);
        $display("test power-on values done");
        lat = $random(seed);
        wr(OFF_CFG, 32'h0000_0003);
        wr(OFF_LAT_D, lat);
        wr(OFF_LAT_A, lat);
        other_rst();
        rd(OFF_ANALOG_SELECT_LOW_H, 32'h0000_001F, ALL);
        rd(OFF_DIR_A, 32'h0000_00FF, ALL);
        rd(OFF_LAT_D, lat & 32'h0000_00FF, ALL);
        rd(OFF_LAT_A, lat & 32'h0000_00FF, ALL);
        wr(OFF_CFG, 32'h0000_0000);
        other_rst();
        rd(OFF_ANALOG_SELECT_LOW_H, 32'h0000_0000, ALL);
        rd(OFF_DIR_A, 32'h0000_003F, ALL);
        rd(OFF_LAT_A, lat & 32'h0000_003F, ALL);
        rd(OFF_PINS_A, 32'h0000_0000, 32'hFFFF_FFEF);
        $display("test configuration and latches done");
        wr(OFF_EVT_MASK, 32'h0000_0002);
        wr(OFF_EVT_STAT, 32'h0000_0007);
        rd(OFF_EVT_STAT, 32'h0000_0000, ALL);
        chk(32'(o_irq), 32'h0000_0000);
        // Random writes carry ones in unimplemented bits too
        for (int i = 0; i < NT; i++) begin
            v[i] = $random(seed);
            wr(TA[i], v[i]);
        end
        wake(1'b0, 1'b0, 2'd1, 3'd3, 1'b0);
        for (int i = 0; i < NT; i++) begin
            rd(TA[i], (v[i] & 32'(TM[i])) | ((TA[i] == OFF_PIR_2) ? 32'h0000_0008 : 32'h0000_0000), ALL);
        end
        rd(OFF_EVT_STAT, 32'h0000_0002, 32'h0000_0002);
        chk(32'(o_irq), 32'h0000_0001);
        wr(OFF_EVT_MASK, 32'h0000_0000);
        repeat (2) @(posedge i_ref_clk);
        chk(32'(o_irq), 32'h0000_0000);
        wr(OFF_EVT_MASK, 32'h0000_0002);
        repeat (2) @(posedge i_ref_clk);
        chk(32'(o_irq), 32'h0000_0001);
        wr(OFF_EVT_STAT, 32'h0000_0002);
        repeat (2) @(posedge i_ref_clk);
        chk(32'(o_irq), 32'h0000_0000);
        other_rst();
        for (int i = 0; i < NT; i++) rd(TA[i], 32'(TV[i]), ALL);
        rd(OFF_LAT_D, lat & 32'h0000_00FF, ALL);
        $display("test wake retention and interrupt done");
        wr(OFF_INT_CTRL, 32'h0000_0080);
        pc = PC_W'($random(seed));
        i_core_pc <= pc;
        exp_pc.push_back(VEC_HIGH);
        wake(1'b1, 1'b1, 2'd2, 3'd0, 1'b0);
        rd(OFF_TOS, 32'(pc), ALL);
        rd(OFF_STK_PTR, 32'h0000_0001, ALL);
        wr(OFF_INT_CTRL, 32'h0000_0040);
        pc = PC_W'($random(seed));
        i_core_pc <= pc;
        exp_pc.push_back(VEC_LOW);
        wake(1'b1, 1'b0, 2'd2, 3'd0, 1'b0);
        rd(OFF_TOS, 32'(pc), ALL);
        rd(OFF_STK_PTR, 32'h0000_0002, ALL);
        // Both global enables clear: no vector, no push
        wr(OFF_INT_CTRL, 32'h0000_0000);
        wake(1'b1, 1'b1, 2'd2, 3'd0, 1'b0);
        rd(OFF_STK_PTR, 32'h0000_0002, ALL);
        $display("test interrupt wake done");
        wr(OFF_INT_CTRL, 32'h0000_0080);
        wr(OFF_IPR_2, 32'h0000_0000);
        wake(1'b1, 1'b1, 2'd2, 3'd0, 1'b1);
        rd(OFF_IPR_2, 32'h0000_00FF, ALL);
        rd(OFF_STK_PTR, 32'h0000_0000, ALL);
        repeat (3) @(posedge i_ref_clk);
        chk(32'(exp_rd.size()), 32'h0000_0000);
        chk(32'(exp_pc.size()), 32'h0000_0000);
        $display("test reset against wake done");
        end_of_test();
    end
endmodule
